// file: common/pifb_pkg.sv
// Shared constants and carrier types for the peripheral flag and enable bank
package pifb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB
  localparam logic [7:0] OFS_FLAGS_ONE    = 8'h00;
  localparam logic [7:0] OFS_FLAGS_TWO    = 8'h04;
  localparam logic [7:0] OFS_FLAGS_THREE  = 8'h08;
  localparam logic [7:0] OFS_FLAGS_FOUR   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS_FIVE   = 8'h10;
  localparam logic [7:0] OFS_ENABLES_ONE  = 8'h14;
  localparam logic [7:0] OFS_IRQ_CONTROL  = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented bits, buffer-cleared bits, reset values
  localparam logic [7:0] IMPL_FLAGS_ONE   = 8'h7F;
  localparam logic [7:0] IMPL_FLAGS_TWO   = 8'hFF;
  localparam logic [7:0] IMPL_FLAGS_THREE = 8'hFF;
  localparam logic [7:0] IMPL_FLAGS_FOUR  = 8'h07;
  localparam logic [7:0] IMPL_FLAGS_FIVE  = 8'h07;
  localparam logic [7:0] IMPL_ENABLES_ONE = 8'h7F;
  localparam logic [7:0] IMPL_IRQ_CONTROL = 8'h03;
  localparam logic [7:0] BUF_FLAGS_MASK   = 8'h30;
  localparam logic [7:0] NO_BUF_MASK      = 8'h00;
  localparam logic [7:0] RESET_BYTE       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Control register field positions
  localparam int CTRL_PERIPH_OR_LOW_BIT   = 0;
  localparam int CTRL_PRIORITY_SCHEME_BIT = 1;

  typedef enum logic [1:0]
  {
    PIFB_CCP_OFF     = 2'h0,
    PIFB_CCP_CAPTURE = 2'h1,
    PIFB_CCP_COMPARE = 2'h2,
    PIFB_CCP_PWM     = 2'h3
  } pifb_ccp_mode_e;

  // One-cycle event pulses from the peripherals, same clock
  typedef struct packed
  {
    logic       converter_done;
    logic       async_one_rx_load;
    logic       async_one_rx_read;
    logic       async_one_tx_empty;
    logic       async_one_tx_write;
    logic       serial_one_done;
    logic       timer_two_match;
    logic       timer_one_overflow;
    logic       osc_fail;
    logic       nv_write_done;
    logic       serial_one_collision;
    logic       timer_three_overflow;
    logic       serial_two_done;
    logic       serial_two_collision;
    logic       async_two_rx_load;
    logic       async_two_rx_read;
    logic       async_two_tx_empty;
    logic       async_two_tx_write;
    logic       charge_timer_event;
    logic       timer_five_gate;
    logic       timer_three_gate;
    logic       timer_one_gate;
    logic       timer_six_match;
    logic       timer_five_overflow;
    logic       timer_four_match;
    logic [4:0] capcmp_capture;
    logic [4:0] capcmp_match;
  } pifb_events_s;

  // Levels from the peripherals, same clock
  typedef struct packed
  {
    logic                 comparator_one_out;
    logic                 comparator_two_out;
    logic                 voltage_above;
    logic                 voltage_trip_direction;
    pifb_ccp_mode_e [4:0] capcmp_mode;
  } pifb_levels_s;

  // Enables of flag registers two to five, held outside this bank
  typedef struct packed
  {
    logic [7:0] two;
    logic [7:0] three;
    logic [7:0] four;
    logic [7:0] five;
  } pifb_ext_enables_s;

endpackage

// file: design/pifb_bank.sv
// Peripheral interrupt flag bank with the first enable register, APB slave
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Contract
// - Capcmp one and two flags set on capture or compare by mode; not in PWM
// - Flags one bit 1 sets on timer two period match; software clears
// - Flags one bit 0 sets on timer one overflow; software clears
// - Flags two bit 7 sets on oscillator failure; software clears
// - Flags two bits 6 and 5 set on comparator one or two output change
// - Flags two bit 4 sets when a nonvolatile write completes
// - Flags two bit 3 sets on serial port one bus collision
// - Flags two bit 2 sets on voltage trip in the selected direction
// - Flags two bit 1 sets on timer three overflow; software clears
// - Flags three bit 7 sets when serial port two finishes a transfer
// - Flags three bit 6 sets on serial two master collision
// - Flags three bit 5 marks async two receive full; cleared by buffer read
// - Flags three bit 4 marks async two transmit empty; cleared by buffer write
// - Flags three bit 3 sets on a charge time unit event
// - Flags three bits 2 to 0 set on timer five, three, one gate events
// - Flags four bits 2 to 0 serve capcmp five, four, three by mode
// - Flags five bits 2 to 0: timer six match, five overflow, four match
// - Unimplemented bits of flags four, five and enables bit 7 read zero
// - Enables one bits 6 to 0 enable their flag; 1 enables
// - Without priority scheme, request reaches core only with peripheral enable
// - Flags set regardless of any enable bit
// - With priority scheme, peripheral enable gates all low-priority requests
module pifb_bank
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire pifb_pkg::pifb_events_s      events,
  input  wire pifb_pkg::pifb_levels_s      levels,
  input  wire pifb_pkg::pifb_ext_enables_s ext_enables,
  output logic                             periph_irq_pending,
  output logic                             periph_irq
);
  import pifb_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Merge of software write, hardware clear and hardware set
  function automatic logic [7:0] next_flag_byte
  (
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic [7:0] buf_clr,
    input logic       wr,
    input logic [7:0] wd,
    input logic [7:0] impl,
    input logic [7:0] buf_mask
  );
    logic [7:0] kept;
    kept = wr ? ((wd & ~buf_mask) | (cur & buf_mask)) : cur;
    return (((kept & ~(buf_clr & buf_mask)) | set) & impl);
  endfunction

  function automatic logic capcmp_hit
  (
    input pifb_ccp_mode_e mode,
    input logic           capture,
    input logic           match
  );
    return ((mode == PIFB_CCP_CAPTURE) && capture) || ((mode == PIFB_CCP_COMPARE) && match);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] flags_one;
  logic [7:0] periph_flags_two;
  logic [7:0] periph_flags_three;
  logic [7:0] periph_flags_four;
  logic [7:0] periph_flags_five;
  logic [7:0] periph_enables_one;
  logic [7:0] irq_control;
  logic       cmp_one_prev;
  logic       cmp_two_prev;
  logic       volt_prev;
  logic       levels_primed;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire        setup_phase = psel && !penable;
  wire        access_wr   = psel && penable && pwrite && pstrb[0];
  wire        sel_one     = paddr == OFS_FLAGS_ONE;
  wire        sel_two     = paddr == OFS_FLAGS_TWO;
  wire        sel_three   = paddr == OFS_FLAGS_THREE;
  wire        sel_four    = paddr == OFS_FLAGS_FOUR;
  wire        sel_five    = paddr == OFS_FLAGS_FIVE;
  wire        sel_en      = paddr == OFS_ENABLES_ONE;
  wire        sel_ctrl    = paddr == OFS_IRQ_CONTROL;
  wire        mapped      = sel_one | sel_two | sel_three | sel_four | sel_five | sel_en | sel_ctrl;
  wire [7:0]  wd          = pwdata[7:0];

  // Unimplemented bits masked here so reads return zero
  wire [7:0] rd_byte = sel_one   ? (flags_one & IMPL_FLAGS_ONE) :
                       sel_two   ? periph_flags_two :
                       sel_three ? periph_flags_three :
                       sel_four  ? (periph_flags_four & IMPL_FLAGS_FOUR) :
                       sel_five  ? (periph_flags_five & IMPL_FLAGS_FIVE) :
                       sel_en    ? (periph_enables_one & IMPL_ENABLES_ONE) :
                       sel_ctrl  ? (irq_control & IMPL_IRQ_CONTROL) :
                       RESET_BYTE;

  // Zero wait states keeps the bank transparent to firmware timing
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode, independent of every enable bit
  wire cmp_one_change = levels_primed && (levels.comparator_one_out != cmp_one_prev);
  wire cmp_two_change = levels_primed && (levels.comparator_two_out != cmp_two_prev);
  wire volt_rise      = levels_primed && levels.voltage_above && !volt_prev;
  wire volt_fall      = levels_primed && !levels.voltage_above && volt_prev;
  wire volt_trip      = levels.voltage_trip_direction ? volt_rise : volt_fall;

  wire [4:0] ccp_hit;
  assign ccp_hit[0] = capcmp_hit(levels.capcmp_mode[0], events.capcmp_capture[0], events.capcmp_match[0]);
  assign ccp_hit[1] = capcmp_hit(levels.capcmp_mode[1], events.capcmp_capture[1], events.capcmp_match[1]);
  assign ccp_hit[2] = capcmp_hit(levels.capcmp_mode[2], events.capcmp_capture[2], events.capcmp_match[2]);
  assign ccp_hit[3] = capcmp_hit(levels.capcmp_mode[3], events.capcmp_capture[3], events.capcmp_match[3]);
  assign ccp_hit[4] = capcmp_hit(levels.capcmp_mode[4], events.capcmp_capture[4], events.capcmp_match[4]);

  wire [7:0] set_one = {1'b0, events.converter_done, events.async_one_rx_load,
                        events.async_one_tx_empty, events.serial_one_done,
                        ccp_hit[0],
                        events.timer_two_match,
                        events.timer_one_overflow};
  wire [7:0] clr_one = {2'b00, events.async_one_rx_read, events.async_one_tx_write, 4'h0};

  wire [7:0] set_two = {events.osc_fail,
                        cmp_one_change, cmp_two_change,
                        events.nv_write_done,
                        events.serial_one_collision,
                        volt_trip,
                        events.timer_three_overflow,
                        ccp_hit[1]};

  wire [7:0] set_three = {events.serial_two_done,
                          events.serial_two_collision,
                          events.async_two_rx_load,
                          events.async_two_tx_empty,
                          events.charge_timer_event,
                          events.timer_five_gate, events.timer_three_gate,
                          events.timer_one_gate};
  wire [7:0] clr_three = {2'b00, events.async_two_rx_read, events.async_two_tx_write, 4'h0};

  wire [7:0] set_four = {5'h00, ccp_hit[4], ccp_hit[3], ccp_hit[2]};
  wire [7:0] set_five = {5'h00, events.timer_six_match, events.timer_five_overflow,
                         events.timer_four_match};

  // Set wins over a same-cycle clear
  wire [7:0] next_one   = next_flag_byte(flags_one, set_one, clr_one, access_wr && sel_one, wd,
                                         IMPL_FLAGS_ONE, BUF_FLAGS_MASK);
  wire [7:0] next_two   = next_flag_byte(periph_flags_two, set_two, RESET_BYTE, access_wr && sel_two, wd,
                                         IMPL_FLAGS_TWO, NO_BUF_MASK);
  wire [7:0] next_three = next_flag_byte(periph_flags_three, set_three, clr_three, access_wr && sel_three, wd,
                                         IMPL_FLAGS_THREE, BUF_FLAGS_MASK);
  wire [7:0] next_four  = next_flag_byte(periph_flags_four, set_four, RESET_BYTE, access_wr && sel_four, wd,
                                         IMPL_FLAGS_FOUR, NO_BUF_MASK);
  wire [7:0] next_five  = next_flag_byte(periph_flags_five, set_five, RESET_BYTE, access_wr && sel_five, wd,
                                         IMPL_FLAGS_FIVE, NO_BUF_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Request gating
  wire       priority_scheme_en      = irq_control[CTRL_PRIORITY_SCHEME_BIT];
  wire       periph_or_low_global_en = irq_control[CTRL_PERIPH_OR_LOW_BIT];
  wire [7:0] live_one   = flags_one & periph_enables_one;
  wire       any_live   = |{live_one,
                            periph_flags_two & ext_enables.two,
                            periph_flags_three & ext_enables.three,
                            periph_flags_four & ext_enables.four,
                            periph_flags_five & ext_enables.five};

  assign periph_irq_pending = any_live;
  // Every source here counts as low priority when the scheme is on
  assign periph_irq = any_live && (priority_scheme_en ? periph_or_low_global_en
                                                      : periph_or_low_global_en);

  ////////////////////////////////////////////////////////////////////////////
  // Flag and enable storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_one          <= RESET_BYTE;
      periph_flags_two   <= RESET_BYTE;
      periph_flags_three <= RESET_BYTE;
      periph_flags_four  <= RESET_BYTE;
      periph_flags_five  <= RESET_BYTE;
    end
    else
    begin
      flags_one          <= next_one;
      periph_flags_two   <= next_two;
      periph_flags_three <= next_three;
      periph_flags_four  <= next_four;
      periph_flags_five  <= next_five;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      periph_enables_one <= RESET_BYTE;
      irq_control        <= RESET_BYTE;
    end
    else if (access_wr)
    begin
      if (sel_en)
        periph_enables_one <= wd & IMPL_ENABLES_ONE;
      if (sel_ctrl)
        irq_control <= wd & IMPL_IRQ_CONTROL;
    end
  end

  // First cycle after reset only samples, so a high comparator is no false change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_one_prev  <= 1'b0;
      cmp_two_prev  <= 1'b0;
      volt_prev     <= 1'b0;
      levels_primed <= 1'b0;
    end
    else
    begin
      cmp_one_prev  <= levels.comparator_one_out;
      cmp_two_prev  <= levels.comparator_two_out;
      volt_prev     <= levels.voltage_above;
      levels_primed <= 1'b1;
    end
  end

  // Read data captured in setup so it stays stable through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata  <= {24'h00_0000, rd_byte};
      pslverr <= !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_tmr1_sets;
    events.timer_one_overflow |=> flags_one[0];
  endproperty
  a_tmr1_sets: assert property (p_tmr1_sets) else $error("timer one overflow flag not set");

  property p_tmr2_holds;
    flags_one[1] && !(access_wr && sel_one && !wd[1]) |=> flags_one[1];
  endproperty
  a_tmr2_holds: assert property (p_tmr2_holds) else $error("timer two flag dropped");

  property p_set_beats_clear;
    events.osc_fail && access_wr && sel_two && !wd[7] |=> periph_flags_two[7];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat set");

  property p_pwm_ignored;
    levels.capcmp_mode[2] == PIFB_CCP_PWM && !periph_flags_four[0] && !(access_wr && sel_four)
      |=> !periph_flags_four[0];
  endproperty
  a_pwm_ignored: assert property (p_pwm_ignored) else $error("capcmp flag set in pwm");

  property p_rx2_cleared;
    events.async_two_rx_read && !events.async_two_rx_load |=> !periph_flags_three[5];
  endproperty
  a_rx2_cleared: assert property (p_rx2_cleared) else $error("rx two flag not cleared");

  property p_tx2_sw_ignored;
    access_wr && sel_three && !events.async_two_tx_write
      |=> periph_flags_three[4] == ($past(periph_flags_three[4]) | $past(events.async_two_tx_empty));
  endproperty
  a_tx2_sw_ignored: assert property (p_tx2_sw_ignored) else $error("tx two flag written");

  property p_reserved_zero;
    psel && penable && !pwrite && (sel_four || sel_five || sel_en) |-> prdata[7] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one");

  property p_gate_off;
    !periph_or_low_global_en |-> !periph_irq;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("request passed closed gate");

  property p_request;
    periph_or_low_global_en && (flags_one[0] && periph_enables_one[0]) |-> periph_irq;
  endproperty
  a_request: assert property (p_request) else $error("enabled flag gave no request");

  property p_cmp_change;
    levels_primed && $changed(levels.comparator_one_out) |=> periph_flags_two[6];
  endproperty
  a_cmp_change: assert property (p_cmp_change) else $error("comparator change missed");

  property p_volt_dir;
    levels.voltage_trip_direction && $rose(levels.voltage_above) && $past(levels_primed)
      |=> periph_flags_two[2];
  endproperty
  a_volt_dir: assert property (p_volt_dir) else $error("voltage trip missed");

  property p_osc_sets;
    events.osc_fail |=> periph_flags_two[7];
  endproperty
  a_osc_sets: assert property (p_osc_sets) else $error("oscillator fail flag not set");

  property p_nv_sets;
    events.nv_write_done |=> periph_flags_two[4];
  endproperty
  a_nv_sets: assert property (p_nv_sets) else $error("write done flag not set");

  property p_col_one_sets;
    events.serial_one_collision |=> periph_flags_two[3];
  endproperty
  a_col_one_sets: assert property (p_col_one_sets) else $error("serial one collision flag not set");

  property p_tmr3_sets;
    events.timer_three_overflow |=> periph_flags_two[1];
  endproperty
  a_tmr3_sets: assert property (p_tmr3_sets) else $error("timer three flag not set");

  property p_ser_two_sets;
    events.serial_two_done |=> periph_flags_three[7];
  endproperty
  a_ser_two_sets: assert property (p_ser_two_sets) else $error("serial two done flag not set");

  property p_col_two_sets;
    events.serial_two_collision |=> periph_flags_three[6];
  endproperty
  a_col_two_sets: assert property (p_col_two_sets) else $error("serial two collision flag not set");

  property p_tx2_cleared;
    events.async_two_tx_write && !events.async_two_tx_empty |=> !periph_flags_three[4];
  endproperty
  a_tx2_cleared: assert property (p_tx2_cleared) else $error("tx two flag not cleared");

  property p_charge_sets;
    events.charge_timer_event |=> periph_flags_three[3];
  endproperty
  a_charge_sets: assert property (p_charge_sets) else $error("charge timer flag not set");

  property p_gate_sets;
    events.timer_one_gate |=> periph_flags_three[0];
  endproperty
  a_gate_sets: assert property (p_gate_sets) else $error("timer one gate flag not set");

  property p_tmr5_sets;
    events.timer_five_overflow |=> periph_flags_five[1];
  endproperty
  a_tmr5_sets: assert property (p_tmr5_sets) else $error("timer five flag not set");

  // Polling must work with the source masked
  property p_polled;
    events.timer_two_match && !periph_enables_one[1] |=> flags_one[1];
  endproperty
  a_polled: assert property (p_polled) else $error("masked flag not set");

  property p_low_gate;
    priority_scheme_en && !periph_or_low_global_en |-> !periph_irq;
  endproperty
  a_low_gate: assert property (p_low_gate) else $error("low priority request passed");

endmodule

// file: testbench/pifb_periph_model.sv
// Behavioural model of the on-chip peripherals feeding the flag bank
`timescale 1ns/10ps
module pifb_periph_model
  import pifb_pkg::*;
(
  input  wire logic            pclk,
  output pifb_pkg::pifb_events_s events,
  output pifb_pkg::pifb_levels_s levels
);
  initial
  begin
    events = '0;
    levels = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle pulse on this clock; the bank has no synchroniser
  task automatic pulse(input logic [$bits(pifb_events_s)-1:0] ev);
    @(posedge pclk);
    events <= pifb_events_s'(ev);
    @(posedge pclk);
    events <= '0;
  endtask

  task automatic set_lv(input pifb_levels_s lv);
    @(posedge pclk);
    levels <= lv;
  endtask
endmodule

// file: testbench/pifb_bank_tb_top.sv
// Self-checking bench for the peripheral flag and enable bank
`timescale 1ns/10ps
module pifb_bank_tb_top;
  import pifb_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic              periph_irq_pending, periph_irq;
  logic [7:0]        paddr, a;
  logic [3:0]        pstrb;
  logic [31:0]       pwdata, prdata, rd;
  logic [34:0]       ev;
  pifb_events_s      events;
  pifb_levels_s      levels, lv;
  pifb_ext_enables_s ext_enables;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                src_k[17] = '{34, 29, 28, 27, 26, 25, 24, 23, 22, 21, 16, 15, 14, 13, 12, 11, 10};
  int                src_bit[17] = '{6, 3, 1, 0, 7, 4, 3, 1, 7, 6, 3, 2, 1, 0, 2, 1, 0};
  logic [7:0]        src_ofs[17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08,
                                     8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h10, 8'h10};
  logic [7:0]        cc_ofs[5] = '{8'h00, 8'h04, 8'h0C, 8'h0C, 8'h0C};
  int                cc_bit[5] = '{2, 0, 0, 1, 2};
  logic [3:0]        lv_seq[5] = '{4'h8, 4'hE, 4'h0, 4'h1, 4'h3};
  logic [7:0]        lv_exp[5] = '{8'h40, 8'h20, 8'h64, 8'h00, 8'h04};
  logic [7:0]        buf_exp[4] = '{8'h20, 8'h00, 8'h10, 8'h00};

  pifb_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .levels(levels), .ext_enables(ext_enables),
    .periph_irq_pending(periph_irq_pending), .periph_irq(periph_irq));
  pifb_periph_model i_model (.pclk(pclk), .events(events), .levels(levels));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Release costs a cycle so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] ad, input logic [7:0] exp);
    apb(1'b0, ad, 8'h00);
    chk(nm, {24'h000000, exp}, rd);
  endtask

  task automatic wr_rd(input logic [7:0] ad, input logic [7:0] wd, input logic [7:0] exp);
    apb(1'b1, ad, wd);
    rchk($sformatf("reg %h", ad), ad, exp);
    chk("slverr", 32'h00000000, {31'h0, err});
  endtask

  task automatic irq_chk(input logic pend, input logic irq);
    @(negedge pclk);
    chk("pending", {31'h0, pend}, {31'h0, periph_irq_pending});
    chk("irq", {31'h0, irq}, {31'h0, periph_irq});
    @(posedge pclk);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    ext_enables = '0;
    lv = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++)
      rchk("reset", 8'(4 * i), 8'h00);
    rchk("unmapped", 8'h1C, 8'h00);
    chk("slverr", 32'h00000001, {31'h0, err});
    done("reset");
    // Holes and buffer-owned bits must not store
    wr_rd(OFS_ENABLES_ONE, 8'hFF, 8'h7F);
    wr_rd(OFS_FLAGS_ONE, 8'hFF, 8'h4F);
    wr_rd(OFS_FLAGS_TWO, 8'hFF, 8'hFF);
    wr_rd(OFS_FLAGS_THREE, 8'hFF, 8'hCF);
    wr_rd(OFS_FLAGS_FOUR, 8'hFF, 8'h07);
    wr_rd(OFS_FLAGS_FIVE, 8'hFF, 8'h07);
    for (int i = 0; i < 6; i++)
      wr_rd(8'(4 * i), 8'h00, 8'h00);
    pstrb <= 4'hE;
    wr_rd(OFS_FLAGS_TWO, 8'hFF, 8'h00);
    pstrb <= 4'hF;
    done("access");
    // All enables clear, so flags must still set
    for (int i = 0; i < 17; i++)
    begin
      ev = '0;
      ev[src_k[i]] = 1'b1;
      i_model.pulse(ev);
      rchk("source", src_ofs[i], 8'h01 << src_bit[i]);
      wr_rd(src_ofs[i], 8'h00, 8'h00);
    end
    for (int u = 0; u < 5; u++)
      for (int m = 0; m < 8; m++)
      begin
        lv.capcmp_mode[u] = pifb_ccp_mode_e'(m % 4);
        i_model.set_lv(lv);
        ev = '0;
        ev[(m < 4) ? 5 + u : u] = 1'b1;
        i_model.pulse(ev);
        rchk("capcmp", cc_ofs[u], (m == 1 || m == 6) ? (8'h01 << cc_bit[u]) : 8'h00);
        apb(1'b1, cc_ofs[u], 8'h00);
      end
    for (int i = 0; i < 5; i++)
    begin
      {lv.comparator_one_out, lv.comparator_two_out, lv.voltage_above, lv.voltage_trip_direction} = lv_seq[i];
      i_model.set_lv(lv);
      @(posedge pclk);
      rchk("levels", OFS_FLAGS_TWO, lv_exp[i]);
      apb(1'b1, OFS_FLAGS_TWO, 8'h00);
    end
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 4; s++)
      begin
        a = p ? OFS_FLAGS_THREE : OFS_FLAGS_ONE;
        ev = '0;
        ev[(p ? 20 : 33) - s] = 1'b1;
        i_model.pulse(ev);
        apb(1'b1, a, 8'h00);
        rchk("buffer", a, buf_exp[s]);
      end
    done("sources");
    apb(1'b1, OFS_ENABLES_ONE, 8'h01);
    ev = '0;
    ev[27] = 1'b1;
    i_model.pulse(ev);
    irq_chk(1'b1, 1'b0);
    apb(1'b1, OFS_IRQ_CONTROL, 8'h01);
    irq_chk(1'b1, 1'b1);
    apb(1'b1, OFS_IRQ_CONTROL, 8'h03);
    irq_chk(1'b1, 1'b1);
    apb(1'b1, OFS_IRQ_CONTROL, 8'h02);
    irq_chk(1'b1, 1'b0);
    apb(1'b1, OFS_ENABLES_ONE, 8'h00);
    irq_chk(1'b0, 1'b0);
    ev = '0;
    ev[26] = 1'b1;
    i_model.pulse(ev);
    ext_enables.two <= 8'h80;
    apb(1'b1, OFS_IRQ_CONTROL, 8'h01);
    irq_chk(1'b1, 1'b1);
    apb(1'b1, OFS_FLAGS_TWO, 8'h00);
    irq_chk(1'b0, 1'b0);
    ext_enables.three <= 8'h01;
    ev = '0;
    ev[13] = 1'b1;
    i_model.pulse(ev);
    irq_chk(1'b1, 1'b1);
    apb(1'b1, OFS_FLAGS_THREE, 8'h00);
    irq_chk(1'b0, 1'b0);
    apb(1'b1, OFS_FLAGS_ONE, 8'h00);
    // Hardware set lands on the same edge as the clearing write
    ev = '0;
    ev[26] = 1'b1;
    fork
      apb(1'b1, OFS_FLAGS_TWO, 8'h00);
      i_model.pulse(ev);
    join
    rchk("set wins", OFS_FLAGS_TWO, 8'h80);
    // Mid-run reset must drop a set flag and raise no false voltage trip edge
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("rereset", OFS_FLAGS_TWO, 8'h00);
    irq_chk(1'b0, 1'b0);
    done("requests");
    wrap_up();
  end
endmodule
